// *** rtl/sdl_loader.sv ***
// Contract
// - a valid start runs six active edges, one word per holding register
// - strobe high at one active edge starts loading on the next only
// - edge phase high loads on rising link edges, low on falling
// - direction low fills channels 0 to 5, high fills 5 to 0
// - transfer high at rising edge copies all holdings on next falling edge
// - power-down clears stored data; resumes afterwards with data reset
// - each sample is one 12-bit unsigned code on the shared bus
// - polarity high gives output above upper reference, low below lower
`timescale 1ns/1ps
module sdl_loader
	import sdl_pkg::*;
#(
	parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// processor-side pins
	input wire logic link_clk,
	input wire logic [CODE_W-1:0] data_bus,
	input wire logic sequence_start_strobe,
	input wire logic output_transfer_strobe,
	// converter side
	output sdl_codes_t channel_output,
	output logic polarity_flip,
	output logic power_down_active,
	output logic sample_ready
);
	localparam int LW = $clog2(FIFO_DEPTH_P+1);

	// stepping past the last channel is harmless: the run ends on that word
	function automatic logic [CHAN_W-1:0] step_chan(input logic [CHAN_W-1:0] c, input logic desc);
		step_chan = desc ? c - 1'b1 : c + 1'b1;
	endfunction

	function automatic logic [3:0] reg_slot(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		reg_slot = (a >= base && d[1:0] == 2'b00 && d[7:2] < 6'(CHANNELS)) ? {1'b1, d[4:2]} : 4'h0;
	endfunction

	// two-stage synchronisers for every pin input
	// data lags by the same two stages as the link clock, so word and edge line up
	logic [2:0] clk_sync;
	logic [CODE_W-1:0] data_s1;
	logic [CODE_W-1:0] data_s2;
	logic [1:0] start_sync;
	logic [1:0] xfr_sync;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_sync <= '0;
			data_s1 <= '0;
			data_s2 <= '0;
			start_sync <= '0;
			xfr_sync <= '0;
		end else begin
			clk_sync <= {clk_sync[1:0], link_clk};
			data_s1 <= data_bus;
			data_s2 <= data_s1;
			start_sync <= {start_sync[0], sequence_start_strobe};
			xfr_sync <= {xfr_sync[0], output_transfer_strobe};
		end
	end

	// edge detect reads only stages two and three
	wire link_rise = clk_sync[1] && !clk_sync[2];
	wire link_fall = !clk_sync[1] && clk_sync[2];

	// control and status registers
	logic [CTRL_W-1:0] ctrl;
	logic overflow;
	wire edge_phase = ctrl[CTRL_EDGE_PHASE];
	wire load_dir = ctrl[CTRL_LOAD_DIR];
	// power-down is a register bit, already on hclk, so no synchroniser
	wire pd = ctrl[CTRL_POWER_DOWN];
	wire act_edge = edge_phase ? link_rise : link_fall;

	// loading sequence
	sdl_seq_t state;
	logic armed;
	logic [CHAN_W-1:0] chan;
	logic [CHAN_W-1:0] count;
	wire start_now = act_edge && armed;
	wire capture = act_edge && (armed || state == SEQ_LOAD) && !pd;
	wire [CHAN_W-1:0] first_chan = load_dir ? CHAN_FIRST_DESC : CHAN_FIRST_ASC;
	wire [CHAN_W-1:0] cur_chan = start_now ? first_chan : chan;
	wire [CHAN_W-1:0] next_count = start_now ? 3'h1 : count + 1'b1;
	sdl_sample_t push_data;
	assign push_data.chan = cur_chan;
	assign push_data.code = data_s2;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= SEQ_IDLE;
			armed <= 1'b0;
			chan <= '0;
			count <= '0;
		end else if (pd) begin
			state <= SEQ_IDLE;
			armed <= 1'b0;
		end else if (act_edge) begin
			armed <= start_sync[1];
			if (capture) begin
				chan <= step_chan(cur_chan, load_dir);
				count <= next_count;
				state <= (next_count == SEQ_WORDS) ? SEQ_IDLE : SEQ_LOAD;
			end
		end
	end

	// buffer between capture and holding registers; link cannot be stalled,
	// so a full buffer drops the word and latches overflow
	logic push_ready;
	logic pop_valid;
	sdl_sample_t pop_data;
	logic [LW-1:0] level;
	wire pop_ready = !ctrl[CTRL_DRAIN_HOLD];

	sdl_fifo #(.WIDTH($bits(sdl_sample_t)), .DEPTH(FIFO_DEPTH_P)) u_fifo (
		.clk(hclk),
		.rst_n(hresetn),
		.flush(pd),
		.in_valid(capture),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_data),
		.level(level)
	);

	// holding registers and output transfer
	// zero after power-down; stored data is lost there and any value would do
	sdl_codes_t holding;
	logic xfr_pending;
	wire do_xfr = link_fall && xfr_pending && !pd;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			holding <= '0;
		end else if (pd) begin
			holding <= '0;
		end else if (pop_valid && pop_ready) begin
			holding[pop_data.chan] <= pop_data.code;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xfr_pending <= 1'b0;
			channel_output <= '0;
		end else if (pd) begin
			xfr_pending <= 1'b0;
			channel_output <= '0;
		end else begin
			if (link_rise) begin
				xfr_pending <= xfr_sync[1];
			end else if (do_xfr) begin
				xfr_pending <= 1'b0;
			end
			if (do_xfr) begin
				channel_output <= holding;
			end
		end
	end

	// output region: code 4095 sits at the reference on either side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			polarity_flip <= 1'b0;
			power_down_active <= 1'b0;
			sample_ready <= 1'b1;
		end else begin
			polarity_flip <= ctrl[CTRL_POLARITY];
			power_down_active <= pd;
			sample_ready <= push_ready;
		end
	end

	// ahb-lite: zero wait states, always okay
	logic wr_pend;
	logic [7:0] wr_addr;
	wire addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
	wire [3:0] hold_slot = reg_slot(haddr[7:0], OFF_HOLD0);
	wire [3:0] out_slot = reg_slot(haddr[7:0], OFF_OUT0);
	wire ctrl_wr = wr_pend && wr_addr == OFF_CTRL;
	wire ovf_clr = wr_pend && wr_addr == OFF_STATUS && hwdata[STAT_OVERFLOW];
	wire ovf_set = capture && !push_ready;
	logic [31:0] status_word;
	logic [31:0] read_word;

	assign status_word = {{(32-STAT_LEVEL_LSB-LW){1'b0}}, level, xfr_pending, overflow, armed, state == SEQ_LOAD};
	assign read_word = (haddr[7:0] == OFF_CTRL) ? {{(32-CTRL_W){1'b0}}, ctrl} :
		(haddr[7:0] == OFF_STATUS) ? status_word :
		hold_slot[3] ? {20'h0, holding[hold_slot[2:0]]} :
		out_slot[3] ? {20'h0, channel_output[out_slot[2:0]]} : 32'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_addr <= haddr[7:0];
			if (addr_ok && !hwrite) begin
				hrdata <= read_word;
			end
		end
	end

	// set wins over a write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RESET;
			overflow <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ctrl <= hwdata[CTRL_W-1:0];
			end
			overflow <= ovf_set || (overflow && !ovf_clr);
		end
	end

	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// counter spans one whole run so the six-word check sees its end
	logic [3:0] seq_pushes;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_pushes <= '0;
		end else if (start_now) begin
			seq_pushes <= {3'h0, capture};
		end else if (capture) begin
			seq_pushes <= seq_pushes + 4'h1;
		end
	end

	sequence s_arm_then_edge;
		act_edge && armed && !pd;
	endsequence

	sequence s_loading_done;
		state == SEQ_LOAD ##1 state == SEQ_IDLE;
	endsequence

	sequence s_xfr_armed;
		link_rise && xfr_sync[1] && !pd;
	endsequence

	a_no_start_unarmed: assert property (act_edge && !armed && state == SEQ_IDLE && !pd |=> state == SEQ_IDLE)
		else $error("loading began without a start strobe");
	a_six_words_run: assert property (s_loading_done ##0 !$past(pd) |-> seq_pushes == 4'h6)
		else $error("sequence did not capture six words");
	a_idle_no_capture: assert property (state == SEQ_IDLE && !armed |-> !capture)
		else $error("capture outside a sequence");
	a_edge_phase_sel: assert property (capture |-> clk_sync[1] == edge_phase && clk_sync[2] == !edge_phase)
		else $error("capture on the wrong link edge");
	a_first_chan_dir: assert property (s_arm_then_edge |-> push_data.chan == (load_dir ? 3'h5 : 3'h0))
		else $error("sequence started on the wrong channel");
	a_xfr_copies_all: assert property (do_xfr |=> channel_output == $past(holding))
		else $error("transfer did not copy holding registers");
	a_pd_clears_data: assert property (pd |=> holding == '0 && channel_output == '0 && state == SEQ_IDLE)
		else $error("power-down kept stored data");
	a_sample_code: assert property (capture |-> push_data.code == data_s2)
		else $error("captured code differs from bus");
	a_polarity_out: assert property (##1 polarity_flip == $past(ctrl[CTRL_POLARITY]))
		else $error("polarity output not following control");
	a_outputs_hold: assert property (!do_xfr && !pd |=> $stable(channel_output))
		else $error("outputs changed without a transfer");
	a_hold_write: assert property (pop_valid && pop_ready && !pd |=> holding[$past(pop_data.chan)] == $past(pop_data.code))
		else $error("drained word did not reach its holding register");
	a_restart_load: assert property (start_now && !pd |=> state == SEQ_LOAD)
		else $error("start strobe did not begin a sequence");
	a_pd_no_capture: assert property (pd |-> !capture && !do_xfr)
		else $error("activity during power-down");
	a_xfr_armed: assert property (s_xfr_armed |=> xfr_pending)
		else $error("transfer strobe at rising edge was lost");
	a_run_count: assert property (state == SEQ_LOAD |-> count != 3'h0 && count < SEQ_WORDS)
		else $error("loading ran past six words");
	a_xfr_single: assert property (do_xfr |=> !xfr_pending)
		else $error("transfer request not retired");
endmodule

// *** rtl/sdl_pkg.sv ***
package sdl_pkg;
	localparam int CHANNELS = 6;
	localparam int CODE_W = 12;
	localparam int CHAN_W = 3;
	localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;
	localparam logic [CHAN_W-1:0] CHAN_FIRST_ASC = 3'h0;
	localparam logic [CHAN_W-1:0] CHAN_FIRST_DESC = 3'h5;
	localparam logic [CHAN_W-1:0] SEQ_WORDS = 3'h6;
	localparam int FIFO_DEPTH = 8;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_HOLD0 = 8'h10;
	localparam logic [7:0] OFF_OUT0 = 8'h30;

	// control fields
	localparam int CTRL_EDGE_PHASE = 0;
	localparam int CTRL_LOAD_DIR = 1;
	localparam int CTRL_POLARITY = 2;
	localparam int CTRL_POWER_DOWN = 3;
	localparam int CTRL_DRAIN_HOLD = 4;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h01;

	// status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_ARMED = 1;
	localparam int STAT_OVERFLOW = 2;
	localparam int STAT_XFR_PEND = 3;
	localparam int STAT_LEVEL_LSB = 4;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [CODE_W-1:0] code;
	} sdl_sample_t;

	typedef logic [CHANNELS-1:0][CODE_W-1:0] sdl_codes_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_LOAD = 2'b10
	} sdl_seq_t;
endpackage

// *** rtl/sdl_fifo.sv ***
`timescale 1ns/1ps
module sdl_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// fill level
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (level != LW'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointer wrap keeps any depth legal, not only powers of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			level <= level + LW'(push) - LW'(pop);
		end
	end

	a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
		level <= LW'(DEPTH)) else $error("fifo level above depth");
	a_fifo_count: assert property (@(posedge clk) disable iff (!rst_n)
		!flush |=> level == $past(level) + LW'($past(push)) - LW'($past(pop)))
		else $error("fifo level miscounted");
endmodule

// *** sim/sdl_proc.sv ***
`timescale 1ns/1ps
module sdl_proc
	import sdl_pkg::*;
#(
	parameter int HALF = 6
) (
	// clock
	input wire logic hclk,
	// processor pins
	output logic link_clk,
	output logic [CODE_W-1:0] data_bus,
	output logic sequence_start_strobe,
	output logic output_transfer_strobe
);
	initial begin
		link_clk = 1'b0;
		data_bus = 12'h000;
		sequence_start_strobe = 1'b0;
		output_transfer_strobe = 1'b0;
	end

	// one link period; clock stands low between calls
	task automatic cyc(input logic ph, input logic [CODE_W-1:0] w, input logic s, input logic x);
		output_transfer_strobe <= x;
		if (ph) begin
			data_bus <= w;
			sequence_start_strobe <= s;
		end
		repeat (HALF) @(posedge hclk);
		link_clk <= 1'b1;
		if (!ph) begin
			data_bus <= w;
			sequence_start_strobe <= s;
		end
		repeat (HALF) @(posedge hclk);
		link_clk <= 1'b0;
	endtask

	// ph picks the link edge the word is set up for: high rising, low falling; trailing word scrambles the bus
	// transfer strobe is left standing: the next call sets it before any edge
	task automatic frame(input logic ph, input logic [CODE_W-1:0] base, input logic x);
		cyc(ph, ~base, 1'b1, 1'b0);
		for (int k = 0; k < CHANNELS; k++) begin
			cyc(ph, base + CODE_W'(k), 1'b0, 1'b0);
		end
		cyc(ph, ~base, 1'b0, x);
	endtask
endmodule

// *** sim/six_channel_dac_input_loader_bench.sv ***
`timescale 1ns/1ps
module six_channel_dac_input_loader_bench
	import sdl_pkg::*;
	;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic link_clk;
	logic [CODE_W-1:0] data_bus;
	logic sequence_start_strobe;
	logic output_transfer_strobe;
	sdl_codes_t channel_output;
	logic polarity_flip;
	logic power_down_active;
	logic sample_ready;
	logic [31:0] d;
	int failures = 0;
	int n_tests = 0;

	always #5 hclk = ~hclk;

	sdl_loader dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .link_clk(link_clk), .data_bus(data_bus),
		.sequence_start_strobe(sequence_start_strobe), .output_transfer_strobe(output_transfer_strobe),
		.channel_output(channel_output), .polarity_flip(polarity_flip),
		.power_down_active(power_down_active), .sample_ready(sample_ready));

	sdl_proc proc_u (.hclk(hclk), .link_clk(link_clk), .data_bus(data_bus),
		.sequence_start_strobe(sequence_start_strobe), .output_transfer_strobe(output_transfer_strobe));

	task automatic close_out();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// bounded wait for hready; a hung bus ends the run
	task automatic rdy();
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && i < 40) begin
			@(posedge hclk);
			i++;
		end
		if (hreadyout !== 1'b1) begin
			failures++;
			$display("[ERR] %0t bus hang", $time);
			close_out();
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		d = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(d, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// six channel registers; dir reverses the fill order, z expects cleared data
	task automatic see(input logic [7:0] off, input logic [CODE_W-1:0] base, input logic dir, input logic z);
		logic [31:0] e;
		for (int c = 0; c < CHANNELS; c++) begin
			e = z ? 32'h0 : {20'h0, base + CODE_W'(dir ? CHANNELS - 1 - c : c)};
			rd(off + 8'(4 * c), e);
			if (off == OFF_OUT0) begin
				chk({20'h0, channel_output[c]}, e);
			end
		end
	endtask

	task automatic t_reset();
		rd(OFF_CTRL, 32'(CTRL_RESET));
		rd(OFF_STATUS, 32'h0);
		rd(8'hFC, 32'h0);
		chk({29'h0, polarity_flip, power_down_active, sample_ready}, 32'h1);
	endtask

	task automatic t_asc();
		proc_u.frame(1'b1, 12'h100, 1'b1);
		repeat (8) @(posedge hclk);
		see(OFF_HOLD0, 12'h100, 1'b0, 1'b0);
		see(OFF_OUT0, 12'h100, 1'b0, 1'b0);
	endtask

	task automatic t_desc();
		ahb(1'b1, OFF_CTRL, 32'h2);
		proc_u.frame(1'b0, 12'hFFA, 1'b0);
		repeat (8) @(posedge hclk);
		see(OFF_HOLD0, 12'hFFA, 1'b1, 1'b0);
		see(OFF_OUT0, 12'h100, 1'b0, 1'b0);
		// words without a start must not reload the holdings
		proc_u.cyc(1'b0, 12'h055, 1'b0, 1'b0);
		proc_u.cyc(1'b0, 12'h0AA, 1'b0, 1'b1);
		proc_u.cyc(1'b0, 12'h0AA, 1'b0, 1'b0);
		repeat (8) @(posedge hclk);
		see(OFF_OUT0, 12'hFFA, 1'b1, 1'b0);
		ahb(1'b1, OFF_CTRL, 32'h6);
		repeat (2) @(posedge hclk);
		chk({31'h0, polarity_flip}, 32'h1);
	endtask

	// drain held so twelve words overrun the eight-word buffer
	task automatic t_fifo();
		ahb(1'b1, OFF_CTRL, 32'h11);
		proc_u.frame(1'b1, 12'h200, 1'b0);
		proc_u.frame(1'b1, 12'h300, 1'b0);
		repeat (8) @(posedge hclk);
		chk({31'h0, sample_ready}, 32'h0);
		ahb(1'b0, OFF_STATUS, 32'h0);
		chk(d & 32'hF4, 32'h84);
		ahb(1'b1, OFF_CTRL, 32'h1);
		repeat (20) @(posedge hclk);
		// drained in order: the second run reached channels 0 and 1 only
		rd(OFF_HOLD0, 32'h300);
		rd(OFF_HOLD0 + 8'h04, 32'h301);
		rd(OFF_HOLD0 + 8'h08, 32'h202);
		ahb(1'b1, OFF_STATUS, 32'h4);
		ahb(1'b0, OFF_STATUS, 32'h0);
		chk(d & 32'hF4, 32'h0);
		chk({31'h0, sample_ready}, 32'h1);
	endtask

	task automatic t_pd();
		ahb(1'b1, OFF_CTRL, 32'h9);
		repeat (2) @(posedge hclk);
		chk({31'h0, power_down_active}, 32'h1);
		proc_u.frame(1'b1, 12'h400, 1'b1);
		ahb(1'b1, OFF_CTRL, 32'h1);
		repeat (2) @(posedge hclk);
		chk({31'h0, power_down_active}, 32'h0);
		see(OFF_HOLD0, 12'h000, 1'b0, 1'b1);
		see(OFF_OUT0, 12'h000, 1'b0, 1'b1);
		// loading and transfer work again once power-down is lifted
		proc_u.frame(1'b1, 12'h500, 1'b1);
		repeat (8) @(posedge hclk);
		see(OFF_OUT0, 12'h500, 1'b0, 1'b0);
	endtask

	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_asc();
		t_desc();
		t_fifo();
		t_pd();
		close_out();
	end
endmodule
